// ---- ccw_ctrl.sv ----
// charge cycle, top-off and watchdog control with apb register access
//
// The implementer's own choices: the APB interface to the registers and the address map.
`include "ccw_params.svh"
`default_nettype none
module ccw_ctrl
    import ccw_pkg::*;
#(
    parameter int TICK_CYCLES = `CCW_TICK_NS / `CCW_CLK_PERIOD_NS,
    parameter int SAFETY_TICKS = `CCW_SAFETY_HOURS * `CCW_MS_PER_HOUR,
    parameter int WDOG_UNIT_TICKS = 40000,
    parameter int TOPOFF_UNIT_TICKS = 900000,
    parameter int BLINK_TICKS = 500
) (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic CHARGE_ENABLE_PIN_N_I,
    input wire logic CONV_READY_I,
    input wire logic THERMISTOR_FAULT_I,
    input wire logic BAT_BELOW_SHORT_I,
    input wire logic BAT_BELOW_PRE_I,
    input wire logic BAT_BELOW_TARGET_I,
    input wire logic BAT_BELOW_RECHG_I,
    input wire logic CHG_BELOW_TERM_I,
    input wire logic IN_CURRENT_REG_I,
    input wire logic IN_VOLT_REG_I,
    input wire logic THERMAL_REG_I,
    input wire logic SUPPLEMENT_NEED_I,
    output logic CHARGE_ON_O,
    output logic BATT_SWITCH_ON_O,
    output logic [1:0] CURRENT_SEL_O,
    output logic RECHG_SEL_O,
    output logic [5:0] FAST_CURRENT_O,
    output logic [4:0] IN_CURRENT_LIMIT_O,
    output logic [3:0] IN_VOLT_LIMIT_O,
    output logic STAT_PIN_O,
    output logic STAT_PIN_OE_O,
    output logic HOST_IRQ_N_O
);
    localparam int IRQ_CYCLES = `CCW_IRQ_PULSE_NS / `CCW_CLK_PERIOD_NS;

    function automatic logic [31:0] unit_mul(input logic [1:0] code,
                                             input int unit);
        unit_mul = 32'(code) * 32'(unit);
    endfunction : unit_mul

    // ============================================================
    // pin synchronisers
    logic [11:0] sync1_reg;
    logic [11:0] sync2_reg;
    always_ff @(posedge SYS_CLK_I) begin
        sync1_reg <= {CHARGE_ENABLE_PIN_N_I, CONV_READY_I, THERMISTOR_FAULT_I,
                      BAT_BELOW_SHORT_I, BAT_BELOW_PRE_I, BAT_BELOW_TARGET_I,
                      BAT_BELOW_RECHG_I, CHG_BELOW_TERM_I, IN_CURRENT_REG_I,
                      IN_VOLT_REG_I, THERMAL_REG_I, SUPPLEMENT_NEED_I};
        sync2_reg <= sync1_reg;
    end
    wire pin_n = sync2_reg[11];
    wire conv_ok = sync2_reg[10];
    wire therm_fault = sync2_reg[9];
    wire below_short = sync2_reg[8];
    wire below_pre = sync2_reg[7];
    wire below_target = sync2_reg[6];
    wire below_rechg = sync2_reg[5];
    wire cur_low = sync2_reg[4];
    wire dpm_reg = sync2_reg[3] | sync2_reg[2];
    wire therm_reg = sync2_reg[1];
    wire supplement = sync2_reg[0];

    // ============================================================
    // apb slave: one wait state, pready and data from flops
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    wire access = PSEL_I & PENABLE_I;
    wire hit_ctrl = PADDR_I == `CCW_ADDR_CTRL;
    wire hit_limit = PADDR_I == `CCW_ADDR_LIMIT;
    wire hit_stat = PADDR_I == `CCW_ADDR_STAT;
    wire mapped = hit_ctrl | hit_limit | hit_stat;
    wire fire = access & pready_reg;
    wire wr_ctrl = fire & PWRITE_I & hit_ctrl;
    wire wr_limit = fire & PWRITE_I & hit_limit;
    wire kick = wr_ctrl & PWDATA_I[`CCW_B_KICK];
    wire reg_rst = wr_ctrl & PWDATA_I[`CCW_B_REG_RST];

    // ============================================================
    // control registers
    logic chg_en_reg;
    logic term_en_reg;
    logic rechg_sel_reg;
    logic force_off_reg;
    logic bsw_dly_reg;
    logic bsw_rst_reg;
    logic [1:0] pin_mode_reg;
    logic [1:0] wdog_per_reg;
    logic [1:0] topoff_set_reg;
    logic [5:0] ichg_reg;
    logic [4:0] iin_reg;
    logic [3:0] vin_reg;
    logic wdog_exp_reg;
    logic wdog_fire;

    // expiry puts the programmable set back to defaults
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I || reg_rst || wdog_fire) begin
            chg_en_reg <= 1'b1;
            term_en_reg <= 1'b1;
            rechg_sel_reg <= 1'b0;
            pin_mode_reg <= `CCW_DEF_PIN_MODE;
            wdog_per_reg <= `CCW_DEF_WDOG_PER;
            topoff_set_reg <= `CCW_DEF_TOPOFF;
            ichg_reg <= `CCW_DEF_ICHG;
        end else if (wr_ctrl) begin
            chg_en_reg <= PWDATA_I[`CCW_B_CHG_EN];
            term_en_reg <= PWDATA_I[`CCW_B_TERM_EN];
            rechg_sel_reg <= PWDATA_I[`CCW_B_RECHG];
            pin_mode_reg <= PWDATA_I[`CCW_B_PIN_MODE +: 2];
            wdog_per_reg <= PWDATA_I[`CCW_B_WDOG_PER +: 2];
            topoff_set_reg <= PWDATA_I[`CCW_B_TOPOFF +: 2];
        end else if (wr_limit) begin
            ichg_reg <= PWDATA_I[`CCW_B_ICHG +: 6];
        end
    end

    // limits and battery switch bits survive watchdog expiry
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I || reg_rst) begin
            force_off_reg <= 1'b0;
            bsw_dly_reg <= 1'b0;
            bsw_rst_reg <= 1'b1;
            iin_reg <= `CCW_DEF_IIN;
            vin_reg <= `CCW_DEF_VIN;
        end else if (wr_ctrl) begin
            force_off_reg <= PWDATA_I[`CCW_B_FORCE_OFF];
            bsw_dly_reg <= PWDATA_I[`CCW_B_BSW_DLY];
            bsw_rst_reg <= PWDATA_I[`CCW_B_BSW_RST];
        end else if (wr_limit) begin
            iin_reg <= PWDATA_I[`CCW_B_IIN +: 5];
            vin_reg <= PWDATA_I[`CCW_B_VIN +: 4];
        end
    end

    // ============================================================
    // millisecond tick, and the slowed tick shared by the safety and top-off timers (the watchdog counts the plain tick)
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    logic half_reg;
    wire slow = dpm_reg | therm_reg;
    wire adv = tick_reg & ~therm_fault & (~slow | half_reg);
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
            half_reg <= 1'b0;
        end else begin
            tick_reg <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
            tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ?
                            32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
            if (tick_reg && slow) begin
                half_reg <= ~half_reg;
            end
        end
    end

    // ============================================================
    // watchdog
    logic [31:0] wdog_cnt_reg;
    wire host_mode = ~wdog_exp_reg;
    wire wdog_on = host_mode & (wdog_per_reg != 2'h0);
    wire [31:0] wdog_lim = unit_mul(wdog_per_reg, WDOG_UNIT_TICKS);
    assign wdog_fire = wdog_on & tick_reg &
                       (wdog_cnt_reg >= wdog_lim - 32'h0000_0001);
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            wdog_exp_reg <= 1'b1;
            wdog_cnt_reg <= 32'h0000_0000;
        end else begin
            if (wdog_fire) begin
                wdog_exp_reg <= 1'b1;
            end else if (kick) begin
                wdog_exp_reg <= 1'b0;
            end
            if (kick || !wdog_on) begin
                wdog_cnt_reg <= 32'h0000_0000;
            end else if (tick_reg) begin
                wdog_cnt_reg <= wdog_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ============================================================
    // charge cycle
    ccw_state_t state_reg;
    ccw_state_t state_next;
    logic [31:0] saf_cnt_reg;
    logic [31:0] top_cnt_reg;
    logic [1:0] top_lat_reg;
    logic pin_n_d_reg;
    logic chg_bit_d_reg;
    wire enabled = chg_en_reg & ~pin_n;
    wire start_ok = conv_ok & ~therm_fault & ~force_off_reg & enabled &
                    (ichg_reg != 6'h00) & below_target;
    wire saf_done = saf_cnt_reg >= 32'(SAFETY_TICKS);
    wire term_ok = term_en_reg & ~below_rechg & cur_low &
                   ~slow;
    wire top_done = adv &
        (top_cnt_reg >= unit_mul(top_lat_reg, TOPOFF_UNIT_TICKS) -
         32'h0000_0001);
    wire pin_enable_edge = pin_n_d_reg & ~pin_n;
    // a toggle of either enable source drops the cycle back to idle
    wire toggled = (pin_n != pin_n_d_reg) | (chg_en_reg != chg_bit_d_reg);
    wire running = (state_reg == CCW_ST_CHG) | (state_reg == CCW_ST_TOPOFF);
    wire enter_top = (state_reg == CCW_ST_CHG) & (state_next == CCW_ST_TOPOFF);
    wire irq_event = running & (state_next == CCW_ST_DONE) | enter_top;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CCW_ST_IDLE: begin
                if (start_ok) begin
                    state_next = CCW_ST_CHG;
                end
            end
            CCW_ST_CHG: begin
                if (!enabled) begin
                    state_next = CCW_ST_IDLE;
                end else if (saf_done) begin
                    state_next = CCW_ST_FAULT;
                end else if (term_ok && topoff_set_reg != 2'h0) begin
                    state_next = CCW_ST_TOPOFF;
                end else if (term_ok) begin
                    state_next = CCW_ST_DONE;
                end
            end
            CCW_ST_TOPOFF: begin
                if (!enabled) begin
                    state_next = CCW_ST_IDLE;
                end else if (saf_done) begin
                    state_next = CCW_ST_FAULT;
                end else if (top_done) begin
                    state_next = CCW_ST_DONE;
                end
            end
            CCW_ST_DONE: begin
                if (!enabled || toggled) begin
                    state_next = CCW_ST_IDLE;
                end else if (below_rechg && start_ok) begin
                    state_next = CCW_ST_CHG;
                end
            end
            CCW_ST_FAULT: begin
                if (!enabled || toggled) begin
                    state_next = CCW_ST_IDLE;
                end
            end
            default: begin
                state_next = CCW_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            state_reg <= CCW_ST_IDLE;
            pin_n_d_reg <= 1'b1;
            chg_bit_d_reg <= 1'b1;
            saf_cnt_reg <= 32'h0000_0000;
            top_cnt_reg <= 32'h0000_0000;
            top_lat_reg <= `CCW_DEF_TOPOFF;
        end else begin
            state_reg <= state_next;
            pin_n_d_reg <= pin_n;
            chg_bit_d_reg <= chg_en_reg;
            if (!running) begin
                saf_cnt_reg <= 32'h0000_0000;
            end else if (adv && !saf_done) begin
                saf_cnt_reg <= saf_cnt_reg + 32'h0000_0001;
            end
            if (enter_top) begin
                top_lat_reg <= topoff_set_reg;
            end
            if (enter_top || pin_enable_edge || reg_rst ||
                state_reg != CCW_ST_TOPOFF) begin
                top_cnt_reg <= 32'h0000_0000;
            end else if (adv) begin
                top_cnt_reg <= top_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ============================================================
    // phase report, current select and battery switch
    logic [1:0] phase_next;
    logic [1:0] phase_reg;
    logic [1:0] sel_next;
    assign sel_next = below_short ? `CCW_SEL_SHORT :
                      below_pre ? `CCW_SEL_PRE : `CCW_SEL_FAST;
    always_comb begin
        case (state_next)
            CCW_ST_CHG, CCW_ST_TOPOFF: begin
                phase_next = below_pre ? CCW_PH_PRE : CCW_PH_FAST;
            end
            CCW_ST_DONE: begin
                phase_next = CCW_PH_DONE;
            end
            default: begin
                phase_next = CCW_PH_OFF;
            end
        endcase
    end

    logic charge_on_reg;
    logic bsw_on_reg;
    logic [1:0] sel_reg;
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            phase_reg <= CCW_PH_OFF;
            charge_on_reg <= 1'b0;
            bsw_on_reg <= 1'b1;
            sel_reg <= `CCW_SEL_SHORT;
        end else begin
            phase_reg <= phase_next;
            charge_on_reg <= (state_next == CCW_ST_CHG) |
                             (state_next == CCW_ST_TOPOFF);
            bsw_on_reg <= ~force_off_reg &
                ~((state_next == CCW_ST_DONE) & ~supplement);
            sel_reg <= sel_next;
        end
    end

    // ============================================================
    // status pin and host interrupt pulse
    logic [15:0] blink_cnt_reg;
    logic blink_reg;
    logic stat_oe_reg;
    logic [15:0] irq_cnt_reg;
    logic irq_n_reg;
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            blink_cnt_reg <= 16'h0000;
            blink_reg <= 1'b0;
            stat_oe_reg <= 1'b0;
            irq_cnt_reg <= 16'h0000;
            irq_n_reg <= 1'b1;
        end else begin
            if (tick_reg) begin
                if (blink_cnt_reg == 16'(BLINK_TICKS - 1)) begin
                    blink_cnt_reg <= 16'h0000;
                    blink_reg <= ~blink_reg;
                end else begin
                    blink_cnt_reg <= blink_cnt_reg + 16'h0001;
                end
            end
            if (pin_mode_reg == `CCW_PIN_MODE_OFF) begin
                stat_oe_reg <= 1'b0;
            end else if (state_reg == CCW_ST_FAULT) begin
                stat_oe_reg <= blink_reg;
            end else begin
                stat_oe_reg <= running;
            end
            // an event during a pulse restarts it rather than being lost
            if (irq_event) begin
                irq_cnt_reg <= 16'(IRQ_CYCLES);
            end else if (irq_cnt_reg != 16'h0000) begin
                irq_cnt_reg <= irq_cnt_reg - 16'h0001;
            end
            irq_n_reg <= ~(irq_event | (irq_cnt_reg > 16'h0001));
        end
    end

    // ============================================================
    // read data
    wire [31:0] rd_ctrl = {20'h0_0000, topoff_set_reg, wdog_per_reg,
                           pin_mode_reg, bsw_rst_reg, bsw_dly_reg,
                           force_off_reg, rechg_sel_reg, term_en_reg,
                           chg_en_reg};
    wire [31:0] rd_limit = {10'h000, ichg_reg, 4'h0, vin_reg, 3'h0, iin_reg};
    wire [31:0] rd_stat = {26'h000_0000, state_reg == CCW_ST_FAULT,
                           host_mode, state_reg == CCW_ST_TOPOFF,
                           wdog_exp_reg, phase_reg};
    wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : hit_limit ? rd_limit :
                         hit_stat ? rd_stat : 32'h0000_0000;
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access & ~pready_reg;
            pslverr_reg <= access & ~pready_reg & ~mapped;
            prdata_reg <= (access & ~pready_reg & ~PWRITE_I) ?
                          rd_mux : 32'h0000_0000;
        end
    end

    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign CHARGE_ON_O = charge_on_reg;
    assign BATT_SWITCH_ON_O = bsw_on_reg;
    assign CURRENT_SEL_O = sel_reg;
    assign RECHG_SEL_O = rechg_sel_reg;
    assign FAST_CURRENT_O = ichg_reg;
    assign IN_CURRENT_LIMIT_O = iin_reg;
    assign IN_VOLT_LIMIT_O = vin_reg;
    assign STAT_PIN_O = 1'b0;
    assign STAT_PIN_OE_O = stat_oe_reg;
    assign HOST_IRQ_N_O = irq_n_reg;
endmodule : ccw_ctrl
`default_nettype wire

// ---- ccw_params.svh ----
// constants for the charge cycle and watchdog control block
//
// Contract
// - power-on reset enters default mode, registers at defaults, expired flag set.
// - default mode charges for the long safety time, then stops; expired flag high.
// - writing 1 to the kick bit enters host mode and clears expired flag.
// - period code zero disables the watchdog; otherwise the host must keep kicking.
// - every kick restarts the watchdog count from zero.
// - expiry sets flag, returns to defaults, keeps limits and battery switch bits.
// - charging enabled only with enable bit 1 and enable pin low.
// - default mode uses the default charge parameter set and long safety time.
// - new cycle needs converter, no faults, switch not forced off, enabled, below target.
// - recharge starts below target minus offset chosen by the offset select bit.
// - after completion, toggling the enable pin or bit starts a new cycle.
// - terminate above recharge level with low current, not while regulating; phase 11, irq.
// - termination enable bit at zero prevents termination.
// - status pin low while charging, released when done, blinks on fault, mode 11 off.
// - phase codes: 00 disabled, 01 precharge, 10 fast, 11 completed.
// - phase and current chosen from battery voltage thresholds.
// - during power management or thermal regulation, no termination, timer at half rate.
// - at cycle end the battery switch opens unless supplement mode is needed.
// - optional top-off timer delays termination, paced like the safety timer.
// - a readable bit shows whether the top-off timer runs.
// - top-off timer resets on pin enable, termination rise or register reset write.
// - top-off settings latched at termination; irq pulse at top-off start and end.
`ifndef CCW_PARAMS_SVH
`define CCW_PARAMS_SVH

`define CCW_CLK_PERIOD_NS 8
`define CCW_TICK_NS 1000000
`define CCW_IRQ_PULSE_NS 256
`define CCW_SAFETY_HOURS 10
`define CCW_MS_PER_HOUR 3600000

`define CCW_ADDR_CTRL 12'h000
`define CCW_ADDR_LIMIT 12'h004
`define CCW_ADDR_STAT 12'h008

`define CCW_B_CHG_EN 0
`define CCW_B_TERM_EN 1
`define CCW_B_RECHG 2
`define CCW_B_FORCE_OFF 3
`define CCW_B_BSW_DLY 4
`define CCW_B_BSW_RST 5
`define CCW_B_PIN_MODE 6
`define CCW_B_WDOG_PER 8
`define CCW_B_TOPOFF 10
`define CCW_B_KICK 12
`define CCW_B_REG_RST 13
`define CCW_B_IIN 0
`define CCW_B_VIN 8
`define CCW_B_ICHG 16

`define CCW_DEF_WDOG_PER 2'h1
`define CCW_DEF_PIN_MODE 2'h0
`define CCW_DEF_TOPOFF 2'h0
`define CCW_DEF_ICHG 6'h22
`define CCW_DEF_IIN 5'h04
`define CCW_DEF_VIN 4'h6
`define CCW_PIN_MODE_OFF 2'h3
`define CCW_SEL_SHORT 2'h0
`define CCW_SEL_PRE 2'h1
`define CCW_SEL_FAST 2'h2

`endif

// ---- ccw_pkg.sv ----
// types shared by the charge cycle and watchdog control block
`default_nettype none
package ccw_pkg;
    typedef enum logic [2:0] {
        CCW_ST_IDLE = 3'b000,
        CCW_ST_CHG = 3'b001,
        CCW_ST_TOPOFF = 3'b010,
        CCW_ST_DONE = 3'b011,
        CCW_ST_FAULT = 3'b100
    } ccw_state_t;
    typedef enum logic [1:0] {
        CCW_PH_OFF = 2'b00,
        CCW_PH_PRE = 2'b01,
        CCW_PH_FAST = 2'b10,
        CCW_PH_DONE = 2'b11
    } ccw_phase_t;
endpackage : ccw_pkg
`default_nettype wire

// ---- ccw_batt_model.sv ----
// battery comparator model turning a level index into threshold flags
`default_nettype none
module ccw_batt_model (
    input wire logic [2:0] level_i,
    output logic below_short_o,
    output logic below_pre_o,
    output logic below_target_o,
    output logic below_rechg_o,
    output logic below_term_o
);
    // ========
    // levels: 0 short, 1 pre, 2 fast, 3 full and tapered, 4 near full
    assign below_short_o = level_i == 3'h0;
    assign below_pre_o = level_i <= 3'h1;
    assign below_target_o = level_i != 3'h3;
    assign below_rechg_o = level_i <= 3'h2;
    // current only tapers once the cell sits at target
    assign below_term_o = level_i == 3'h3;
endmodule : ccw_batt_model
`default_nettype wire

// ---- ccw_ctrl_monitor.sv ----
// port assertions for the charge cycle and watchdog control block
`include "ccw_params.svh"
`default_nettype none
module ccw_ctrl_monitor (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    input wire logic CHARGE_ENABLE_PIN_N_I,
    input wire logic CONV_READY_I,
    input wire logic THERMISTOR_FAULT_I,
    input wire logic BAT_BELOW_SHORT_I,
    input wire logic CHARGE_ON_O,
    input wire logic [1:0] CURRENT_SEL_O,
    input wire logic [5:0] FAST_CURRENT_O,
    input wire logic [4:0] IN_CURRENT_LIMIT_O,
    input wire logic [3:0] IN_VOLT_LIMIT_O,
    input wire logic STAT_PIN_O,
    input wire logic HOST_IRQ_N_O
);
    // ========
    // helpers
    int irq_low;
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);
    // counted in logic: a 32-cycle repeat would be slow to unroll
    always_ff @(posedge SYS_CLK_I) begin
        irq_low <= (RESET_I || HOST_IRQ_N_O) ? 0 : irq_low + 1;
    end
    // five samples cover sync, state and output register latency
    sequence pin_off_s;
        CHARGE_ENABLE_PIN_N_I [*5];
    endsequence
    sequence fault_idle_s;
        THERMISTOR_FAULT_I [*5] ##0 !CHARGE_ON_O;
    endsequence
    // ========
    // assertions
    ready_pulse_a: assert property (PREADY_O |->
        $past(PSEL_I && PENABLE_I) ##1 !PREADY_O)
        else $error("ready not a single cycle answer");
    stat_drive_a: assert property (STAT_PIN_O == 1'b0)
        else $error("status pin drives high");
    pin_off_a: assert property (pin_off_s |-> !CHARGE_ON_O)
        else $error("charging with enable pin high");
    fault_start_a: assert property (fault_idle_s |=> !CHARGE_ON_O)
        else $error("cycle started during thermistor fault");
    conv_start_a: assert property (!CONV_READY_I [*5] ##0 !CHARGE_ON_O
        |=> !CHARGE_ON_O)
        else $error("cycle started without converter");
    irq_width_a: assert property (
        $rose(HOST_IRQ_N_O) |-> irq_low >= 32)
        else $error("host interrupt pulse too short");
    short_sel_a: assert property (BAT_BELOW_SHORT_I [*5] ##0 CHARGE_ON_O
        |-> CURRENT_SEL_O == `CCW_SEL_SHORT)
        else $error("short current not selected");
    reset_def_a: assert property ($fell(RESET_I) |-> FAST_CURRENT_O ==
        `CCW_DEF_ICHG && IN_CURRENT_LIMIT_O == `CCW_DEF_IIN
        && IN_VOLT_LIMIT_O == `CCW_DEF_VIN)
        else $error("limits not at defaults after reset");
endmodule : ccw_ctrl_monitor
`default_nettype wire

// ---- charge_cycle_watchdog_control_test.sv ----
// self-checking bench for the charge cycle and watchdog control block
`include "ccw_params.svh"
`default_nettype none
module charge_cycle_watchdog_control_test
    import ccw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] lv; logic [1:0] sel; ccw_phase_t ph;
        logic on; int irq;} ccw_row_t;
    logic SYS_CLK_I = 0, RESET_I = 1, PSEL_I = 0, PENABLE_I = 0;
    logic PWRITE_I = 0, CHARGE_ENABLE_PIN_N_I = 0, CONV_READY_I = 1;
    logic THERMISTOR_FAULT_I = 0, IN_CURRENT_REG_I = 0, IN_VOLT_REG_I = 0;
    logic THERMAL_REG_I = 0, SUPPLEMENT_NEED_I = 0, PREADY_O, PSLVERR_O;
    logic BAT_BELOW_SHORT_I, BAT_BELOW_PRE_I, BAT_BELOW_TARGET_I, er;
    logic BAT_BELOW_RECHG_I, CHG_BELOW_TERM_I, CHARGE_ON_O, HOST_IRQ_N_O;
    logic BATT_SWITCH_ON_O, RECHG_SEL_O, STAT_PIN_O, STAT_PIN_OE_O;
    logic [1:0] CURRENT_SEL_O;
    logic [5:0] FAST_CURRENT_O;
    logic [4:0] IN_CURRENT_LIMIT_O;
    logic [3:0] IN_VOLT_LIMIT_O;
    logic [11:0] PADDR_I = '0;
    logic [31:0] PWDATA_I = '0, PRDATA_O, rd;
    logic [2:0] lvl = 3'h0;
    int miscompares = 0, n_tests = 0, irq_falls = 0;
    // ========
    // rows: level, current select, phase, charging, interrupt count
    ccw_row_t rows [7] = '{'{0, 0, CCW_PH_PRE, 1, 0},
        '{1, 1, CCW_PH_PRE, 1, 0}, '{2, 2, CCW_PH_FAST, 1, 0},
        '{3, 0, CCW_PH_DONE, 0, 1}, '{4, 0, CCW_PH_DONE, 0, 1},
        '{2, 2, CCW_PH_FAST, 1, 1}, '{3, 0, CCW_PH_DONE, 0, 2}};
    ccw_ctrl #(.TICK_CYCLES(4), .SAFETY_TICKS(5000), .WDOG_UNIT_TICKS(10),
        .TOPOFF_UNIT_TICKS(5), .BLINK_TICKS(2)) DUT (.*);
    ccw_batt_model u_batt (.level_i(lvl), .below_short_o(BAT_BELOW_SHORT_I),
        .below_pre_o(BAT_BELOW_PRE_I), .below_target_o(BAT_BELOW_TARGET_I),
        .below_rechg_o(BAT_BELOW_RECHG_I), .below_term_o(CHG_BELOW_TERM_I));
    always #4 SYS_CLK_I = ~SYS_CLK_I;
    always @(negedge HOST_IRQ_N_O) irq_falls++;
    // ========
    // tasks
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK_I);
    endtask : cyc
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge SYS_CLK_I);
        PSEL_I <= 1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge SYS_CLK_I);
        PENABLE_I <= 1;
        do @(posedge SYS_CLK_I); while (PREADY_O !== 1'b1);
        rd = PRDATA_O;
        er = PSLVERR_O;
        PSEL_I <= 0;
        PENABLE_I <= 0;
    endtask : apb
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        cyc(5000);
        miscompares++;
        tally_and_finish();
    end
    // ========
    // sequence
    initial begin
        cyc(3);
        RESET_I <= 0;
        foreach (rows[i]) begin
            lvl <= rows[i].lv;
            cyc(8);
            apb(0, `CCW_ADDR_STAT, '0);
            chk("phase", rd[1:0], rows[i].ph);
            chk("on", {CHARGE_ON_O, STAT_PIN_OE_O, BATT_SWITCH_ON_O},
                {3{rows[i].on}});
            chk("irq", irq_falls, rows[i].irq);
            if (rows[i].on) chk("sel", CURRENT_SEL_O, rows[i].sel);
        end
        $display("test profile done");
        RESET_I <= 1;
        cyc(3);
        RESET_I <= 0;
        apb(0, `CCW_ADDR_STAT, '0);
        chk("stat", rd[4:2], 3'h1);
        apb(0, `CCW_ADDR_CTRL, '0);
        chk("ctrl", rd, 32'h0000_0123);
        apb(0, `CCW_ADDR_LIMIT, '0);
        chk("limit", rd, 32'h0022_0604);
        $display("test reset done");
        apb(1, `CCW_ADDR_CTRL, 32'h0000_1123);
        apb(1, `CCW_ADDR_LIMIT, 32'h0010_0A05);
        apb(1, `CCW_ADDR_CTRL, 32'h0000_113F);
        cyc(25);
        chk("rsel", RECHG_SEL_O, 1'b1);
        apb(1, `CCW_ADDR_CTRL, 32'h0000_113F);
        apb(0, `CCW_ADDR_STAT, '0);
        chk("host", rd[4:2], 3'h4);
        cyc(60);
        apb(0, `CCW_ADDR_STAT, '0);
        chk("expired", rd[4:2], 3'h1);
        apb(0, `CCW_ADDR_CTRL, '0);
        chk("kept ctrl", rd, 32'h0000_013B);
        apb(0, `CCW_ADDR_LIMIT, '0);
        chk("kept limit", rd, 32'h0022_0A05);
        apb(1, `CCW_ADDR_CTRL, 32'h0000_1023);
        cyc(80);
        apb(0, `CCW_ADDR_STAT, '0);
        chk("no expiry", rd[4:2], 3'h4);
        apb(0, 12'h00C, '0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped", rd, 32'h0000_0000);
        $display("test watchdog done");
        apb(1, `CCW_ADDR_CTRL, 32'h0000_0021);
        lvl <= 3'h2;
        cyc(8);
        lvl <= 3'h3;
        cyc(8);
        chk("no term", CHARGE_ON_O, 1'b1);
        IN_CURRENT_REG_I <= 1;
        apb(1, `CCW_ADDR_CTRL, 32'h0000_0023);
        cyc(8);
        chk("regulating", CHARGE_ON_O, 1'b1);
        IN_CURRENT_REG_I <= 0;
        cyc(12);
        chk("terminated", CHARGE_ON_O, 1'b0);
        lvl <= 3'h4;
        cyc(8);
        chk("near full", CHARGE_ON_O, 1'b0);
        apb(1, `CCW_ADDR_CTRL, 32'h0000_0022);
        apb(1, `CCW_ADDR_CTRL, 32'h0000_0023);
        cyc(8);
        chk("toggled", CHARGE_ON_O, 1'b1);
        CHARGE_ENABLE_PIN_N_I <= 1;
        cyc(8);
        apb(0, `CCW_ADDR_STAT, '0);
        chk("disabled", rd[1:0], CCW_PH_OFF);
        THERMISTOR_FAULT_I <= 1;
        CONV_READY_I <= 0;
        CHARGE_ENABLE_PIN_N_I <= 0;
        cyc(12);
        chk("fault", CHARGE_ON_O, 1'b0);
        THERMISTOR_FAULT_I <= 0;
        CONV_READY_I <= 1;
        cyc(8);
        chk("start", CHARGE_ON_O, 1'b1);
        apb(1, `CCW_ADDR_CTRL, 32'h0000_0423);
        lvl <= 3'h3;
        cyc(6);
        apb(0, `CCW_ADDR_STAT, '0);
        chk("topoff", rd[3:0], 4'hA);
        cyc(30);
        apb(0, `CCW_ADDR_STAT, '0);
        chk("topoff end", rd[3:0], 4'h3);
        $display("test cycle control done");
        tally_and_finish();
    end
endmodule : charge_cycle_watchdog_control_test
bind ccw_ctrl ccw_ctrl_monitor u_mon (.*);
`default_nettype wire
